// [design/gcsa_sync.v]
`timescale 1ns/1ns
module gcsa_sync #(
   parameter W = 3
) (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_i,
   // Asynchronous levels in, synchronised levels out
   input wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // Pins idle high: contacts are open until grounded
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= {W{1'b1}};
         sync_q <= {W{1'b1}};
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule // gcsa_sync

// [design/gcsa_top.v]
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "gcsa_consts.vh"
module gcsa_top (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // Discrete contact inputs, grounded when active
   input wire fil_en_n_i,
   input wire emis_sel_n_i,
   input wire degas_n_i,
   // Serial command channel from the protocol decoder
   input wire ser_cmd_valid_i,
   input wire [2:0] ser_cmd_i,
   input wire ser_arg_i,
   // Measurement path
   input wire [15:0] pressure_i,
   input wire emission_fail_i,
   input wire relay_one_i,
   // Gauge control
   output wire filament_on_o,
   output wire emission_4ma_o,
   output wire degas_on_o,
   output wire measure_en_o,
   // Display control
   output wire [6:0] contrast_o,
   output wire analysis_display_mode_o,
   output wire flip_screen_o,
   output wire [1:0] unit_o,
   output wire [3:0] gas_o,
   output wire menu_ext_o,
   output wire relay_one_indicator_o,
   output wire [1:0] fault_code_o
);

   // Pressure at or above a threshold on the monotone code scale
   function at_or_above;
      input [15:0] p;
      input [15:0] thr;
      begin
         at_or_above = (p >= thr);
      end
   endfunction

   wire [2:0] pins_sync;
   wire fil_pin;
   wire emis_pin;
   wire degas_pin;

   gcsa_sync #(.W(3)) u_sync (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .async_i({degas_n_i, emis_sel_n_i, fil_en_n_i}),
      .sync_o(pins_sync)
   );
   assign fil_pin = ~pins_sync[0];
   assign emis_pin = ~pins_sync[1];
   assign degas_pin = ~pins_sync[2];

   reg [6:0] contrast_q;
   reg mode_q;
   reg flip_q;
   reg [1:0] unit_q;
   reg [3:0] gas_q;
   reg [1:0] src_q;
   reg [15:0] limit_q;
   reg [7:0] sens_q;
   reg sens_valid_q;
   reg filament_q;
   reg emis4_q;
   reg degas_q;
   reg [1:0] fault_q;
   reg measure_q;
   reg relay_ind_q;
   reg menu_ext_q;
   reg pready_q;
   reg pslverr_q;
   reg [31:0] prdata_q;

   // APB decode; the access completes in its first access cycle
   wire setup = psel_i & ~penable_i;
   wire access = psel_i & penable_i & pready_q;
   wire wr = access & pwrite_i;
   wire a_cfg = (paddr_i == `GCSA_CFG_OFF);
   wire a_lim = (paddr_i == `GCSA_LIMIT_OFF);
   wire a_cmd = (paddr_i == `GCSA_CMD_OFF);
   wire a_stat = (paddr_i == `GCSA_STAT_OFF);
   wire a_sens = (paddr_i == `GCSA_SENS_OFF);
   wire mapped = a_cfg | a_lim | a_cmd | a_stat | a_sens;
   wire wr_cfg = wr & a_cfg;
   wire wr_lim = wr & a_lim;
   wire wr_cmd = wr & a_cmd;
   wire wr_sens = wr & a_sens;

   wire cmd_def = wr_cmd & pwdata_i[`GCSA_CMD_DEFAULTS];
   wire cmd_clr = wr_cmd & pwdata_i[`GCSA_CMD_FCLEAR];
   wire [6:0] w_contr = pwdata_i[`GCSA_CFG_CONTR_MSB:`GCSA_CFG_CONTR_LSB];
   wire [1:0] w_unit = pwdata_i[`GCSA_CFG_UNIT_MSB:`GCSA_CFG_UNIT_LSB];
   wire [1:0] w_src = pwdata_i[`GCSA_CFG_SRC_MSB:`GCSA_CFG_SRC_LSB];

   // Configuration registers
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         contrast_q <= `GCSA_CONTR_DEF;
         mode_q <= 1'b0;
         flip_q <= 1'b0;
         unit_q <= `GCSA_UNIT_TORR;
         gas_q <= `GCSA_GAS_N2;
         limit_q <= `GCSA_P_LIMIT_DEF;
         sens_q <= 8'h00;
         sens_valid_q <= 1'b0;
      end else if (cmd_def) begin
         contrast_q <= `GCSA_CONTR_DEF;
         mode_q <= 1'b0;
         flip_q <= 1'b0;
         unit_q <= `GCSA_UNIT_TORR;
         gas_q <= `GCSA_GAS_N2;
         limit_q <= `GCSA_P_LIMIT_DEF;
         sens_valid_q <= 1'b0;
      end else begin
         if (wr_cfg) begin
            // Out-of-range contrast keeps the committed value
            if (w_contr >= `GCSA_CONTR_MIN && w_contr <= `GCSA_CONTR_MAX) begin
               contrast_q <= w_contr;
            end
            mode_q <= pwdata_i[`GCSA_CFG_MODE_BIT];
            flip_q <= pwdata_i[`GCSA_CFG_FLIP_BIT];
            if (w_unit != 2'h3) begin
               unit_q <= w_unit;
            end
            gas_q <= pwdata_i[`GCSA_CFG_GAS_MSB:`GCSA_CFG_GAS_LSB];
         end
         if (wr_lim && !at_or_above(pwdata_i[15:0], `GCSA_P_LIMIT_MAX + 16'h0001)) begin
            limit_q <= pwdata_i[15:0];
         end
         if (wr_sens) begin
            sens_q <= pwdata_i[7:0];
            sens_valid_q <= 1'b1;
         end
      end
   end

   // Control source arbitration
   wire ser_cmd = ser_cmd_valid_i &&
      (ser_cmd_i == `GCSA_SER_FIL_ON || ser_cmd_i == `GCSA_SER_FIL_OFF ||
       ser_cmd_i == `GCSA_SER_DEGAS_ON || ser_cmd_i == `GCSA_SER_DEGAS_OFF ||
       ser_cmd_i == `GCSA_SER_EMIS);
   wire ser_rst = ser_cmd_valid_i && (ser_cmd_i == `GCSA_SER_RESET);
   wire in_disc = (src_q == `GCSA_SRC_DISCRETE);
   wire in_ser = (src_q == `GCSA_SRC_SERIAL);
   wire in_panel = (src_q == `GCSA_SRC_PANEL);
   wire takeover = in_disc & ser_cmd;
   wire ser_live = in_ser | takeover;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         src_q <= `GCSA_SRC_DISCRETE;
      end else begin
         case (src_q)
            `GCSA_SRC_DISCRETE: begin
               if (ser_cmd) begin
                  src_q <= `GCSA_SRC_SERIAL;
               end else if (wr_cfg && w_src != 2'h3 &&
                            w_src != `GCSA_SRC_SERIAL) begin
                  src_q <= w_src;
               end else if (cmd_def) begin
                  src_q <= `GCSA_SRC_DISCRETE;
               end
            end
            `GCSA_SRC_SERIAL: begin
               // Local writes cannot take control back
               if (ser_rst) begin
                  src_q <= `GCSA_SRC_DISCRETE;
               end
            end
            `GCSA_SRC_PANEL: begin
               if (cmd_def) begin
                  src_q <= `GCSA_SRC_DISCRETE;
               end else if (wr_cfg && w_src == `GCSA_SRC_DISCRETE) begin
                  src_q <= w_src;
               end
            end
            default: begin
               src_q <= `GCSA_SRC_DISCRETE;
            end
         endcase
      end
   end

   // Requests from whichever source holds control
   reg on_req;
   reg off_req;
   reg emis_set;
   reg emis_val;
   reg dg_on;
   reg dg_off;
   always @* begin
      on_req = 1'b0;
      off_req = 1'b0;
      emis_set = 1'b0;
      emis_val = emis4_q;
      dg_on = 1'b0;
      dg_off = 1'b0;
      if (ser_live) begin
         if (takeover) begin
            dg_off = 1'b1; // safe state
         end
         if (ser_cmd_valid_i) begin
            case (ser_cmd_i)
               `GCSA_SER_FIL_ON: on_req = 1'b1;
               `GCSA_SER_FIL_OFF: off_req = 1'b1;
               `GCSA_SER_DEGAS_ON: dg_on = ~takeover;
               `GCSA_SER_DEGAS_OFF: dg_off = 1'b1;
               `GCSA_SER_EMIS: begin
                  emis_set = 1'b1;
                  emis_val = ser_arg_i;
               end
               default: on_req = 1'b0;
            endcase
         end
      end else if (in_panel) begin
         on_req = wr_cmd & pwdata_i[`GCSA_CMD_FIL_ON];
         off_req = wr_cmd & pwdata_i[`GCSA_CMD_FIL_OFF];
         dg_on = wr_cmd & pwdata_i[`GCSA_CMD_DEGAS_ON];
         dg_off = wr_cmd & pwdata_i[`GCSA_CMD_DEGAS_OFF];
         if (wr_cmd & pwdata_i[`GCSA_CMD_EMIS_4MA]) begin
            emis_set = 1'b1;
            emis_val = 1'b1;
         end else if (wr_cmd & pwdata_i[`GCSA_CMD_EMIS_100UA]) begin
            emis_set = 1'b1;
            emis_val = 1'b0;
         end
      end else begin
         on_req = fil_pin;
         off_req = ~fil_pin;
         emis_set = 1'b1;
         emis_val = emis_pin;
         dg_on = degas_pin;
         dg_off = ~degas_pin;
      end
   end

   // Trip thresholds and turn-on permission
   wire [15:0] trip_thr = emis4_q ? `GCSA_P_CUT_4MA : limit_q;
   wire over_p = filament_q & at_or_above(pressure_i, trip_thr);
   wire emis_f = filament_q & emission_fail_i;
   wire fault_ev = over_p | emis_f;
   wire p_ok_4ma = ~at_or_above(pressure_i, `GCSA_P_CUT_4MA + 16'h0001);
   wire on_ok = (fault_q == `GCSA_FLT_NONE) & ~fault_ev &
      (~emis4_q | p_ok_4ma);

   // Fault latch; a new fault wins over a clear in the same cycle
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fault_q <= `GCSA_FLT_NONE;
      end else if (over_p) begin
         fault_q <= `GCSA_FLT_OVERP;
      end else if (emis_f) begin
         fault_q <= `GCSA_FLT_EMIS;
      end else if (cmd_clr) begin
         fault_q <= `GCSA_FLT_NONE;
      end
   end

   // Filament, emission and degas state
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         filament_q <= 1'b0;
         emis4_q <= 1'b0;
         degas_q <= 1'b0;
         measure_q <= 1'b0;
      end else begin
         if (fault_ev) begin
            filament_q <= 1'b0;
         end else if (off_req) begin
            filament_q <= 1'b0;
         end else if (on_req && on_ok) begin
            filament_q <= 1'b1;
         end
         // Emission follows whichever source holds control
         if (emis_set) begin
            emis4_q <= emis_val;
         end
         if (fault_ev || !filament_q || dg_off || off_req) begin
            degas_q <= 1'b0;
         end else if (dg_on) begin
            degas_q <= 1'b1;
         end
         measure_q <= filament_q & ~fault_ev &
            (fault_q == `GCSA_FLT_NONE);
      end
   end

   // Display side outputs
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         relay_ind_q <= 1'b0;
         menu_ext_q <= 1'b0;
      end else begin
         relay_ind_q <= relay_one_i & ~mode_q;
         menu_ext_q <= in_panel;
      end
   end

   // APB response
   wire [31:0] cfg_rd = {15'h0000, src_q, gas_q, unit_q, flip_q, mode_q,
      contrast_q};
   wire [31:0] stat_rd = {20'h0_0000, sens_valid_q, menu_ext_q,
      relay_ind_q, measure_q, fault_q, degas_q, emis4_q, filament_q,
      src_q, 1'b0};
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~mapped;
         if (setup && !pwrite_i) begin
            if (a_cfg) begin
               prdata_q <= cfg_rd;
            end else if (a_lim) begin
               prdata_q <= {16'h0000, limit_q};
            end else if (a_stat) begin
               prdata_q <= stat_rd;
            end else if (a_sens) begin
               prdata_q <= {24'h00_0000, sens_q};
            end else begin
               prdata_q <= 32'h0000_0000;
            end
         end
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign filament_on_o = filament_q;
   assign emission_4ma_o = emis4_q;
   assign degas_on_o = degas_q;
   assign measure_en_o = measure_q;
   assign contrast_o = contrast_q;
   assign analysis_display_mode_o = mode_q;
   assign flip_screen_o = flip_q;
   assign unit_o = unit_q;
   assign gas_o = gas_q;
   assign menu_ext_o = menu_ext_q;
   assign relay_one_indicator_o = relay_ind_q;
   assign fault_code_o = fault_q;
endmodule // gcsa_top

// [dv/gcsa_host_model.sv]
`timescale 1ns/1ns
module gcsa_host_model (
   // Clock
   input logic core_clk_i,
   // Contact lines, grounded when active
   output logic fil_en_n_o,
   output logic emis_sel_n_o,
   output logic degas_n_o,
   // Serial command channel
   output logic ser_cmd_valid_o,
   output logic [2:0] ser_cmd_o,
   output logic ser_arg_o
);
   initial begin
      {fil_en_n_o, emis_sel_n_o, degas_n_o} = 3'h7;
      {ser_cmd_valid_o, ser_cmd_o, ser_arg_o} = 5'h00;
   end
   // Contacts stay grounded for as long as the function is wanted
   task pins(input logic f, input logic e, input logic d);
      fil_en_n_o <= ~f;
      emis_sel_n_o <= ~e;
      degas_n_o <= ~d;
   endtask
   // Idle code lines flip so stale codes cannot pass for fresh ones
   task send(input logic [2:0] c, input logic a);
      ser_cmd_valid_o <= 1'b1;
      ser_cmd_o <= c;
      ser_arg_o <= a;
      @(posedge core_clk_i);
      ser_cmd_valid_o <= 1'b0;
      ser_cmd_o <= ~c;
      ser_arg_o <= ~a;
      @(posedge core_clk_i);
   endtask
endmodule // gcsa_host_model

// [dv/gcsa_top_checker.sv]
`timescale 1ns/1ns
module gcsa_top_checker (
   // Clock and reset
   input logic core_clk_i,
   input logic rst_i,
   // Bus handshake
   input logic psel_i,
   input logic penable_i,
   input logic pready_o,
   input logic pslverr_o,
   // Measurement path
   input logic [15:0] pressure_i,
   input logic emission_fail_i,
   input logic relay_one_i,
   // Gauge and display outputs
   input logic filament_on_o,
   input logic emission_4ma_o,
   input logic degas_on_o,
   input logic measure_en_o,
   input logic [6:0] contrast_o,
   input logic [1:0] unit_o,
   input logic relay_one_indicator_o,
   input logic [1:0] fault_code_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   property p_apb_answer;
      psel_i && !penable_i |=> pready_o ##1 !pready_o;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("pready not a single cycle after setup");
   property p_err_ready;
      pslverr_o |-> pready_o;
   endproperty
   a_err_ready: assert property (p_err_ready)
      else $error("pslverr without pready");
   property p_fault_safe;
      fault_code_o != 2'h0 |-> !filament_on_o && !degas_on_o && !measure_en_o;
   endproperty
   a_fault_safe: assert property (p_fault_safe)
      else $error("gauge active while fault held");
   property p_emis_fail;
      filament_on_o && emission_fail_i |=> fault_code_o != 2'h0 && !filament_on_o;
   endproperty
   a_emis_fail: assert property (p_emis_fail)
      else $error("emission failure not handled");
   property p_cut_4ma;
      filament_on_o && emission_4ma_o && pressure_i >= 16'h8000
         |=> fault_code_o == 2'h1 && !filament_on_o;
   endproperty
   a_cut_4ma: assert property (p_cut_4ma)
      else $error("high emission cut-off missed");
   property p_latched;
      $rose(filament_on_o) |-> fault_code_o == 2'h0;
   endproperty
   a_latched: assert property (p_latched)
      else $error("filament on with fault latched");
   property p_on_4ma;
      $rose(filament_on_o) && emission_4ma_o && $past(emission_4ma_o)
         |-> $past(pressure_i) <= 16'h8000;
   endproperty
   a_on_4ma: assert property (p_on_4ma)
      else $error("high emission start above cut-off");
   property p_degas_start;
      $rose(degas_on_o) |-> $past(filament_on_o) && filament_on_o;
   endproperty
   a_degas_start: assert property (p_degas_start)
      else $error("degas started without filament");
   property p_contrast;
      contrast_o >= 7'h01 && contrast_o <= 7'h78;
   endproperty
   a_contrast: assert property (p_contrast)
      else $error("contrast out of range");
   property p_unit;
      unit_o != 2'h3;
   endproperty
   a_unit: assert property (p_unit)
      else $error("illegal pressure unit");
   property p_relay_ind;
      !relay_one_i |=> !relay_one_indicator_o;
   endproperty
   a_relay_ind: assert property (p_relay_ind)
      else $error("relay indicator shown while released");
endmodule // gcsa_top_checker

bind gcsa_top gcsa_top_checker i_gcsa_top_checker (.core_clk_i(core_clk_i),
   .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .pressure_i(pressure_i),
   .emission_fail_i(emission_fail_i), .relay_one_i(relay_one_i),
   .filament_on_o(filament_on_o), .emission_4ma_o(emission_4ma_o),
   .degas_on_o(degas_on_o), .measure_en_o(measure_en_o),
   .contrast_o(contrast_o), .unit_o(unit_o),
   .relay_one_indicator_o(relay_one_indicator_o),
   .fault_code_o(fault_code_o));

// [dv/tb_gauge_control_source_arbiter.sv]
`timescale 1ns/1ns
module tb_gauge_control_source_arbiter;
   typedef struct {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic e;
      logic [1:0] fm;
   } gcsa_row_t;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [15:0] pressure_i = 16'h0100;
   logic emission_fail_i = 1'b0;
   logic relay_one_i = 1'b0;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, fil_en_n_i, emis_sel_n_i, degas_n_i;
   wire ser_cmd_valid_i, ser_arg_i, filament_on_o, emission_4ma_o;
   wire degas_on_o, measure_en_o, analysis_display_mode_o;
   wire flip_screen_o, menu_ext_o, relay_one_indicator_o;
   wire [2:0] ser_cmd_i;
   wire [6:0] contrast_o;
   wire [1:0] unit_o, fault_code_o;
   wire [3:0] gas_o;
   int err_total = 0;
   int n_checks = 0;
   logic [31:0] rd;
   logic er;
   gcsa_row_t rows[10] = '{
      '{8'h00, 32'h0000_7DF8, 32'h0000_7DF8, 1'b0, 2'b11},
      '{8'h00, 32'h0000_7D80, 32'h0000_7DF8, 1'b0, 2'b11},
      '{8'h00, 32'h0000_7DF9, 32'h0000_7DF8, 1'b0, 2'b11},
      '{8'h00, 32'h0000_7FF8, 32'h0000_7DF8, 1'b0, 2'b11},
      '{8'h00, 32'h0000_0201, 32'h0000_0201, 1'b0, 2'b00},
      '{8'h04, 32'h0000_C000, 32'h0000_C000, 1'b0, 2'b00},
      '{8'h04, 32'h0000_C001, 32'h0000_C000, 1'b0, 2'b00},
      '{8'h10, 32'h0000_000A, 32'h0000_000A, 1'b0, 2'b00},
      '{8'h20, 32'h0000_1234, 32'h0000_0000, 1'b1, 2'b00},
      '{8'h08, 32'h0000_0000, 32'h0000_0000, 1'b0, 2'b00}};
   int pb[6] = '{2, 4, 6, 7, 5, 3};
   logic [2:0] pe[6] = '{3'h4, 3'h6, 3'h7, 3'h6, 3'h4, 3'h0};

   gcsa_top i_gcsa_top (.core_clk_i, .rst_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .fil_en_n_i, .emis_sel_n_i, .degas_n_i, .ser_cmd_valid_i, .ser_cmd_i,
      .ser_arg_i, .pressure_i, .emission_fail_i, .relay_one_i,
      .filament_on_o, .emission_4ma_o, .degas_on_o, .measure_en_o,
      .contrast_o, .analysis_display_mode_o, .flip_screen_o, .unit_o,
      .gas_o, .menu_ext_o, .relay_one_indicator_o, .fault_code_o);
   gcsa_host_model i_gcsa_host_model (.core_clk_i,
      .fil_en_n_o(fil_en_n_i), .emis_sel_n_o(emis_sel_n_i),
      .degas_n_o(degas_n_i), .ser_cmd_valid_o(ser_cmd_valid_i),
      .ser_cmd_o(ser_cmd_i), .ser_arg_o(ser_arg_i));

   always #5 core_clk_i = ~core_clk_i;

   task tick(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Idle edge after release keeps strobes from double assignment
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) chk(32'h0, 32'h1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task tally_and_finish;
      $display("errors %0d checks %0d", err_total, n_checks);
      if (err_total == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      #200_000;
      err_total++;
      tally_and_finish;
   end

   initial begin
      tick(2);
      rst_i <= 1'b0;
      tick(1);
      chk({filament_on_o, fault_code_o, unit_o, gas_o, contrast_o}, 7'h0A);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         chk(rd, rows[i].x);
         chk(er, rows[i].e);
         chk({flip_screen_o, analysis_display_mode_o}, rows[i].fm);
      end
      chk({contrast_o, unit_o}, 9'h005);
      relay_one_i <= 1'b1;
      tick(2);
      chk(relay_one_indicator_o, 1'b1);
      relay_one_i <= 1'b0;
      tick(2);
      chk(relay_one_indicator_o, 1'b0);
      i_gcsa_host_model.pins(1'b0, 1'b0, 1'b1);
      tick(5);
      chk(degas_on_o, 1'b0);
      i_gcsa_host_model.pins(1'b1, 1'b0, 1'b1);
      tick(5);
      chk({filament_on_o, emission_4ma_o, degas_on_o}, 3'h5);
      i_gcsa_host_model.pins(1'b1, 1'b1, 1'b0);
      tick(5);
      chk({filament_on_o, emission_4ma_o, degas_on_o}, 3'h6);
      pressure_i <= 16'h8000;
      tick(2);
      chk({filament_on_o, measure_en_o, fault_code_o}, 4'h1);
      tick(3);
      chk(filament_on_o, 1'b0);
      pressure_i <= 16'h7FFF;
      apb(1'b1, 8'h08, 32'h0000_0002);
      tick(5);
      chk({filament_on_o, fault_code_o}, 3'h4);
      emission_fail_i <= 1'b1;
      tick(1);
      emission_fail_i <= 1'b0;
      tick(1);
      chk(fault_code_o, 2'h2);
      pressure_i <= 16'h8001;
      apb(1'b1, 8'h08, 32'h0000_0002);
      tick(5);
      chk({filament_on_o, fault_code_o}, 3'h0);
      apb(1'b1, 8'h04, 32'h0000_5000);
      i_gcsa_host_model.pins(1'b1, 1'b0, 1'b0);
      pressure_i <= 16'h4FFF;
      tick(5);
      chk(filament_on_o, 1'b1);
      pressure_i <= 16'h5000;
      tick(2);
      chk(fault_code_o, 2'h1);
      pressure_i <= 16'h0100;
      apb(1'b1, 8'h08, 32'h0000_0002);
      tick(5);
      i_gcsa_host_model.send(3'h0, 1'b0);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd[2:1], 2'h0);
      i_gcsa_host_model.send(3'h1, 1'b0);
      chk(filament_on_o, 1'b1);
      i_gcsa_host_model.pins(1'b0, 1'b0, 1'b0);
      tick(5);
      apb(1'b0, 8'h0C, 32'h0);
      chk({rd[2:1], filament_on_o}, 3'h3);
      i_gcsa_host_model.send(3'h3, 1'b0);
      chk(degas_on_o, 1'b1);
      i_gcsa_host_model.send(3'h5, 1'b1);
      chk(emission_4ma_o, 1'b1);
      i_gcsa_host_model.send(3'h4, 1'b0);
      i_gcsa_host_model.send(3'h2, 1'b0);
      chk({filament_on_o, degas_on_o}, 2'h0);
      apb(1'b1, 8'h00, 32'h0001_0201);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd[16:15], 2'h1);
      i_gcsa_host_model.send(3'h6, 1'b0);
      i_gcsa_host_model.pins(1'b1, 1'b0, 1'b0);
      tick(5);
      chk(filament_on_o, 1'b1);
      i_gcsa_host_model.send(3'h2, 1'b0);
      chk(filament_on_o, 1'b0);
      i_gcsa_host_model.send(3'h6, 1'b0);
      i_gcsa_host_model.pins(1'b0, 1'b0, 1'b0);
      tick(5);
      apb(1'b1, 8'h00, 32'h0001_0201);
      tick(1);
      chk(menu_ext_o, 1'b1);
      i_gcsa_host_model.pins(1'b1, 1'b1, 1'b1);
      foreach (pb[i]) begin
         apb(1'b1, 8'h08, 32'h1 << pb[i]);
         i_gcsa_host_model.send(3'h2, 1'b0);
         tick(4);
         chk({filament_on_o, emission_4ma_o, degas_on_o}, pe[i]);
      end
      i_gcsa_host_model.pins(1'b0, 1'b0, 1'b0);
      apb(1'b1, 8'h10, 32'h0000_0055);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd[11], 1'b1);
      apb(1'b1, 8'h08, 32'h0000_0001);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000_000A);
      apb(1'b0, 8'h0C, 32'h0);
      chk({rd[11], menu_ext_o}, 2'h0);
      apb(1'b1, 8'h00, 32'h0000_0078);
      rst_i <= 1'b1;
      tick(2);
      chk({filament_on_o, contrast_o}, 8'h0A);
      rst_i <= 1'b0;
      tick(2);
      chk({filament_on_o, contrast_o}, 8'h0A);
      tally_and_finish;
   end
endmodule // tb_gauge_control_source_arbiter

// [pkg/gcsa_consts.vh]
`ifndef GCSA_CONSTS_VH
`define GCSA_CONSTS_VH

// Register byte offsets
`define GCSA_CFG_OFF 8'h00
`define GCSA_LIMIT_OFF 8'h04
`define GCSA_CMD_OFF 8'h08
`define GCSA_STAT_OFF 8'h0C
`define GCSA_SENS_OFF 8'h10

// Configuration fields
`define GCSA_CFG_CONTR_LSB 0
`define GCSA_CFG_CONTR_MSB 6
`define GCSA_CFG_MODE_BIT 7
`define GCSA_CFG_FLIP_BIT 8
`define GCSA_CFG_UNIT_LSB 9
`define GCSA_CFG_UNIT_MSB 10
`define GCSA_CFG_GAS_LSB 11
`define GCSA_CFG_GAS_MSB 14
`define GCSA_CFG_SRC_LSB 15
`define GCSA_CFG_SRC_MSB 16

// Command register bits (write one to act)
`define GCSA_CMD_DEFAULTS 0
`define GCSA_CMD_FCLEAR 1
`define GCSA_CMD_FIL_ON 2
`define GCSA_CMD_FIL_OFF 3
`define GCSA_CMD_EMIS_4MA 4
`define GCSA_CMD_EMIS_100UA 5
`define GCSA_CMD_DEGAS_ON 6
`define GCSA_CMD_DEGAS_OFF 7

// Value limits and factory values
`define GCSA_CONTR_MIN 7'h01
`define GCSA_CONTR_MAX 7'h78
`define GCSA_CONTR_DEF 7'h0A
`define GCSA_GAS_N2 4'h0
`define GCSA_UNIT_TORR 2'h0
`define GCSA_UNIT_MBAR 2'h1
`define GCSA_UNIT_PA 2'h2

// Control sources
`define GCSA_SRC_DISCRETE 2'h0
`define GCSA_SRC_SERIAL 2'h1
`define GCSA_SRC_PANEL 2'h2

// Serial command codes
`define GCSA_SER_READ 3'h0
`define GCSA_SER_FIL_ON 3'h1
`define GCSA_SER_FIL_OFF 3'h2
`define GCSA_SER_DEGAS_ON 3'h3
`define GCSA_SER_DEGAS_OFF 3'h4
`define GCSA_SER_EMIS 3'h5
`define GCSA_SER_RESET 3'h6

// Fault codes
`define GCSA_FLT_NONE 2'h0
`define GCSA_FLT_OVERP 2'h1
`define GCSA_FLT_EMIS 2'h2

// Pressure codes: monotone torr scale of the measurement path
`define GCSA_P_LIMIT_MAX 16'hC000
`define GCSA_P_CUT_4MA 16'h8000
`define GCSA_P_LIMIT_DEF 16'hC000

`endif
